// File: hdl/sbs_consts.svh
`ifndef SBS_CONSTS_SVH
`define SBS_CONSTS_SVH

// register indexes; byte address is four times the index
`define SBS_IDX_HOST_CFG_RD 8'h20
`define SBS_IDX_HOST_CFG_WR 8'ha0
`define SBS_IDX_PER_CFG_WR 8'hba
`define SBS_IDX_PER_CFG_RD 8'hbb
`define SBS_IDX_IRQ_STATUS 8'hc0
`define SBS_IDX_IRQ_CLEAR 8'hc1
`define SBS_IDX_IRQ_ENABLE 8'hc2
`define SBS_IDX_CONTROL 8'hc3
`define SBS_IDX_LINE_STATUS 8'hc4

// hardware configuration field positions
`define SBS_CFG_INT_POL 0
`define SBS_CFG_DREQ_POL 1
`define SBS_CFG_DACK_POL 2
`define SBS_CFG_MERGE_IRQ 3
`define SBS_CFG_MERGE_DMA 4
`define SBS_CFG_INT_EN 5

// writable bits and reset values
`define SBS_HOST_CFG_MASK 16'h003f
`define SBS_PER_CFG_MASK 16'h0027
`define SBS_CFG_RST 16'h0000

// interrupt status bit positions
`define SBS_EV_HOST_WAKE 0
`define SBS_EV_PER_WAKE 1
`define SBS_EV_HOST_GRANT 2
`define SBS_EV_PER_GRANT 3

// control register bit
`define SBS_CTL_POWER_ON 0

// timing
`define SBS_CLK_PERIOD_NS 4
`define SBS_WAKE_FILT_NS 20
`define SBS_WAKE_FILT_CYC \
    ((`SBS_WAKE_FILT_NS + `SBS_CLK_PERIOD_NS - 1) / `SBS_CLK_PERIOD_NS)

`endif

// File: hdl/sbs_pkg.sv
package sbs_pkg;

    // apb request from the master
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } sbs_apb_req_s;

    // open-drain pin drive
    typedef struct packed {
        logic out;
        logic oe;
    } sbs_od_s;

    typedef enum logic [1:0] {
        SBS_SW_DRIVE,
        SBS_SW_SETTLE,
        SBS_SW_ARMED,
        SBS_SW_FILTER
    } sbs_sw_e;

    // sleep/wake pin state
    typedef struct packed {
        logic meta;
        logic sync;
        sbs_sw_e st;
        logic [3:0] cnt;
        logic oe;
        logic wake;
        logic level;
    } sbs_sw_s;

    // main block state
    typedef struct packed {
        logic [15:0] host_cfg;
        logic [15:0] per_cfg;
        logic [3:0] irq_stat;
        logic [3:0] irq_en;
        logic power_on;
        logic dack_h_meta;
        logic dack_h_sync;
        logic dack_p_meta;
        logic dack_p_sync;
        logic dreq_h;
        logic dreq_p;
        logic irq_h;
        logic irq_p;
        logic grant_h;
        logic grant_p;
        logic sb_irq;
        logic psw_oe;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } sbs_main_s;

endpackage : sbs_pkg

// File: hdl/sbs_sideband.sv
// Summary of operation
// - host dma ack decoded with programmed level
// - periph dma ack decoded with programmed level
// - host irq pin shows host events, configured
// - irq merge puts both irqs on host
// - periph irq pin shows periph events, configured
// - host sleep pin released in suspend
// - periph sleep pin released in suspend
// - power switch driven low turns vbus on
// - power switch released high turns vbus off
// - switch serves external charge pump supply
// - dma merge routes both channels host pins
//
// Our own choices: register access over APB and the placing of the registers.
`include "sbs_consts.svh"

module sbs_sideband (
    input wire logic pclk,
    input wire logic presetn,
    input sbs_pkg::sbs_apb_req_s apb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic host_ctrl_irq,
    input wire logic periph_ctrl_irq,
    input wire logic host_ctrl_dma_req,
    input wire logic periph_ctrl_dma_req,
    input wire logic host_ctrl_suspend,
    input wire logic periph_ctrl_suspend,
    output logic host_ctrl_dma_grant,
    output logic periph_ctrl_dma_grant,
    output logic host_ctrl_wake,
    output logic periph_ctrl_wake,
    input wire logic dma_ack_host,
    input wire logic dma_ack_periph,
    output logic dma_req_host,
    output logic dma_req_periph,
    output logic irq_host_out,
    output logic irq_periph_out,
    input wire logic host_sleep_wake_in,
    output sbs_pkg::sbs_od_s host_sleep_wake,
    input wire logic periph_sleep_wake_in,
    output sbs_pkg::sbs_od_s periph_sleep_wake,
    output sbs_pkg::sbs_od_s port1_power_switch_n,
    output logic sb_irq
);
    import sbs_pkg::*;

    sbs_main_s q;
    sbs_main_s d;
    logic host_wake;
    logic per_wake;
    logic host_level;
    logic per_level;

    // register address match for a word index
    function automatic logic sbs_hit(input logic [11:0] addr,
                                     input logic [7:0] idx);
        sbs_hit = (addr == {2'b00, idx, 2'b00});
    endfunction : sbs_hit

    // drive a pin at its programmed active level
    function automatic logic sbs_level(input logic active,
                                       input logic pol_high);
        sbs_level = pol_high ? active : ~active;
    endfunction : sbs_level

    // host sleep/wake pin
    sbs_sleep_wake u_host_sw (
        .pclk(pclk),
        .presetn(presetn),
        .suspend(host_ctrl_suspend),
        .pin_in(host_sleep_wake_in),
        .pin(host_sleep_wake),
        .wake(host_wake),
        .level(host_level)
    );

    // peripheral sleep/wake pin
    sbs_sleep_wake u_per_sw (
        .pclk(pclk),
        .presetn(presetn),
        .suspend(periph_ctrl_suspend),
        .pin_in(periph_sleep_wake_in),
        .pin(periph_sleep_wake),
        .wake(per_wake),
        .level(per_level)
    );

    // next state of the whole block
    always_comb
    begin
        logic merge_dma;
        logic merge_irq;
        logic ack_h;
        logic ack_p;
        logic req_h;
        logic req_p;
        logic irq_h;
        logic irq_p;
        logic acc;
        logic wr;
        logic [3:0] ev;
        logic [3:0] clr;
        logic [31:0] rd;
        logic mapped;
        merge_dma = 1'b0;
        merge_irq = 1'b0;
        ack_h = 1'b0;
        ack_p = 1'b0;
        req_h = 1'b0;
        req_p = 1'b0;
        irq_h = 1'b0;
        irq_p = 1'b0;
        acc = 1'b0;
        wr = 1'b0;
        ev = 4'h0;
        clr = 4'h0;
        rd = 32'h0000_0000;
        mapped = 1'b0;
        d = q;

        merge_dma = q.host_cfg[`SBS_CFG_MERGE_DMA];
        merge_irq = q.host_cfg[`SBS_CFG_MERGE_IRQ];

        // two-stage synchronisers for the acknowledge pins
        d.dack_h_meta = dma_ack_host;
        d.dack_h_sync = q.dack_h_meta;
        d.dack_p_meta = dma_ack_periph;
        d.dack_p_sync = q.dack_p_meta;

        // acknowledge decoded at its programmed level
        ack_h = (q.dack_h_sync == q.host_cfg[`SBS_CFG_DACK_POL]);
        ack_p = (q.dack_p_sync == q.per_cfg[`SBS_CFG_DACK_POL]);

        // request and grant routing, merged onto host pins if selected
        if (merge_dma)
        begin
            req_h = host_ctrl_dma_req | periph_ctrl_dma_req;
            req_p = 1'b0;
            d.grant_h = ack_h & host_ctrl_dma_req;
            d.grant_p = ack_h & ~host_ctrl_dma_req
                & periph_ctrl_dma_req;
        end
        else
        begin
            req_h = host_ctrl_dma_req;
            req_p = periph_ctrl_dma_req;
            d.grant_h = ack_h & host_ctrl_dma_req;
            d.grant_p = ack_p & periph_ctrl_dma_req;
        end
        d.dreq_h = sbs_level(req_h, q.host_cfg[`SBS_CFG_DREQ_POL]);
        d.dreq_p = sbs_level(req_p, q.per_cfg[`SBS_CFG_DREQ_POL]);

        // interrupt pins, periph merged onto host pin if selected
        irq_h = q.host_cfg[`SBS_CFG_INT_EN]
            & (host_ctrl_irq | (merge_irq & periph_ctrl_irq));
        irq_p = q.per_cfg[`SBS_CFG_INT_EN] & ~merge_irq
            & periph_ctrl_irq;
        d.irq_h = sbs_level(irq_h, q.host_cfg[`SBS_CFG_INT_POL]);
        d.irq_p = sbs_level(irq_p, q.per_cfg[`SBS_CFG_INT_POL]);

        // power switch: drive low for on, release for off
        d.psw_oe = q.power_on;

        // apb: one wait state, effect at the completing edge
        acc = apb.psel & apb.penable & q.pready;
        wr = acc & apb.pwrite;
        d.pready = apb.psel & apb.penable & ~q.pready;

        // read mux and address decode
        if (sbs_hit(apb.paddr, `SBS_IDX_HOST_CFG_RD)
            || sbs_hit(apb.paddr, `SBS_IDX_HOST_CFG_WR))
        begin
            mapped = 1'b1;
            rd = {16'h0000, q.host_cfg};
        end
        else if (sbs_hit(apb.paddr, `SBS_IDX_PER_CFG_RD)
            || sbs_hit(apb.paddr, `SBS_IDX_PER_CFG_WR))
        begin
            mapped = 1'b1;
            rd = {16'h0000, q.per_cfg};
        end
        else if (sbs_hit(apb.paddr, `SBS_IDX_IRQ_STATUS))
        begin
            mapped = 1'b1;
            rd = {28'h000_0000, q.irq_stat};
        end
        else if (sbs_hit(apb.paddr, `SBS_IDX_IRQ_CLEAR))
        begin
            mapped = 1'b1;
            rd = 32'h0000_0000;
        end
        else if (sbs_hit(apb.paddr, `SBS_IDX_IRQ_ENABLE))
        begin
            mapped = 1'b1;
            rd = {28'h000_0000, q.irq_en};
        end
        else if (sbs_hit(apb.paddr, `SBS_IDX_CONTROL))
        begin
            mapped = 1'b1;
            rd = {31'h0000_0000, q.power_on};
        end
        else if (sbs_hit(apb.paddr, `SBS_IDX_LINE_STATUS))
        begin
            mapped = 1'b1;
            rd = {24'h00_0000, q.psw_oe, q.dreq_p, q.dreq_h, ack_p, ack_h,
                per_level, host_level, host_ctrl_suspend};
        end
        else
        begin
            mapped = 1'b0;
            rd = 32'h0000_0000;
        end

        if (d.pready)
        begin
            d.prdata = apb.pwrite ? 32'h0000_0000 : rd;
            d.pslverr = ~mapped;
        end
        else
        begin
            d.prdata = 32'h0000_0000;
            d.pslverr = 1'b0;
        end

        // register writes
        if (wr && mapped)
        begin
            if (sbs_hit(apb.paddr, `SBS_IDX_HOST_CFG_RD)
                || sbs_hit(apb.paddr, `SBS_IDX_HOST_CFG_WR))
            begin
                d.host_cfg = apb.pwdata[15:0] & `SBS_HOST_CFG_MASK;
            end
            else if (sbs_hit(apb.paddr, `SBS_IDX_PER_CFG_RD)
                || sbs_hit(apb.paddr, `SBS_IDX_PER_CFG_WR))
            begin
                d.per_cfg = apb.pwdata[15:0] & `SBS_PER_CFG_MASK;
            end
            else if (sbs_hit(apb.paddr, `SBS_IDX_IRQ_CLEAR))
            begin
                clr = apb.pwdata[3:0];
            end
            else if (sbs_hit(apb.paddr, `SBS_IDX_IRQ_ENABLE))
            begin
                d.irq_en = apb.pwdata[3:0];
            end
            else if (sbs_hit(apb.paddr, `SBS_IDX_CONTROL))
            begin
                d.power_on = apb.pwdata[`SBS_CTL_POWER_ON];
            end
        end

        // sticky events; a new event beats a clear in the same cycle
        ev[`SBS_EV_HOST_WAKE] = host_wake;
        ev[`SBS_EV_PER_WAKE] = per_wake;
        ev[`SBS_EV_HOST_GRANT] = d.grant_h & ~q.grant_h;
        ev[`SBS_EV_PER_GRANT] = d.grant_p & ~q.grant_p;
        d.irq_stat = (q.irq_stat & ~clr) | ev;
        d.sb_irq = |(d.irq_stat & d.irq_en);
    end

    // state register; pins start at their inactive levels
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            q <= '0;
            q.host_cfg <= `SBS_CFG_RST;
            q.per_cfg <= `SBS_CFG_RST;
            q.dreq_h <= 1'b1;
            q.dreq_p <= 1'b1;
            q.irq_h <= 1'b1;
            q.irq_p <= 1'b1;
        end
        else
        begin
            q <= d;
        end
    end

    // outputs straight from the state register
    assign prdata = q.prdata;
    assign pready = q.pready;
    assign pslverr = q.pslverr;
    assign host_ctrl_dma_grant = q.grant_h;
    assign periph_ctrl_dma_grant = q.grant_p;
    assign dma_req_host = q.dreq_h;
    assign dma_req_periph = q.dreq_p;
    assign irq_host_out = q.irq_h;
    assign irq_periph_out = q.irq_p;
    assign port1_power_switch_n = '{out: 1'b0, oe: q.psw_oe};
    assign sb_irq = q.sb_irq;
    assign host_ctrl_wake = host_wake;
    assign periph_ctrl_wake = per_wake;

endmodule : sbs_sideband

// File: hdl/sbs_sleep_wake.sv
`include "sbs_consts.svh"

module sbs_sleep_wake (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic suspend,
    input wire logic pin_in,
    output sbs_pkg::sbs_od_s pin,
    output logic wake,
    output logic level
);
    import sbs_pkg::*;

    localparam logic [3:0] FILT_CYC = 4'(`SBS_WAKE_FILT_CYC);

    sbs_sw_s q;
    sbs_sw_s d;

    // drive low while awake, release in suspend, watch for a low pulse
    always_comb
    begin
        d = q;
        d.meta = pin_in;
        d.sync = q.meta;
        d.level = q.sync;
        d.wake = 1'b0;
        case (q.st)
            SBS_SW_DRIVE:
            begin
                if (suspend)
                begin
                    d.st = SBS_SW_SETTLE;
                end
            end
            SBS_SW_SETTLE:
            begin
                // wait for the pull-up so our own low is not a wake
                if (!suspend)
                begin
                    d.st = SBS_SW_DRIVE;
                end
                else if (q.sync)
                begin
                    d.st = SBS_SW_ARMED;
                end
            end
            SBS_SW_ARMED:
            begin
                if (!suspend)
                begin
                    d.st = SBS_SW_DRIVE;
                end
                else if (!q.sync)
                begin
                    d.st = SBS_SW_FILTER;
                    d.cnt = 4'h1;
                end
            end
            SBS_SW_FILTER:
            begin
                // low must last the filter time; shorter is a glitch
                if (!suspend)
                begin
                    d.st = SBS_SW_DRIVE;
                end
                else if (q.sync)
                begin
                    d.st = SBS_SW_ARMED;
                end
                else if (q.cnt >= FILT_CYC - 4'h1)
                begin
                    d.wake = 1'b1;
                    d.st = SBS_SW_DRIVE;
                end
                else
                begin
                    d.cnt = q.cnt + 4'h1;
                end
            end
            default:
            begin
                d.st = SBS_SW_DRIVE;
            end
        endcase
        d.oe = (d.st == SBS_SW_DRIVE);
    end

    // state register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            q <= '0;
            q.st <= SBS_SW_DRIVE;
            q.oe <= 1'b1;
        end
        else
        begin
            q <= d;
        end
    end

    assign pin = '{out: 1'b0, oe: q.oe};
    assign wake = q.wake;
    assign level = q.level;

endmodule : sbs_sleep_wake

// File: tb/sbs_far_side.sv
module sbs_far_side (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pol,
    input wire logic [3:0] lat,
    input wire logic pull_h,
    input wire logic pull_p,
    input wire logic dma_req_host,
    input wire logic dma_req_periph,
    input sbs_pkg::sbs_od_s host_sleep_wake,
    input sbs_pkg::sbs_od_s periph_sleep_wake,
    input sbs_pkg::sbs_od_s port1_power_switch_n,
    output logic dma_ack_host,
    output logic dma_ack_periph,
    output logic host_sleep_wake_in,
    output logic periph_sleep_wake_in,
    output logic vbus_on
);
    import sbs_pkg::*;
    logic [3:0] wh;
    logic [3:0] wp;

    // pull-up wins unless the device or the far side pulls low
    assign host_sleep_wake_in =
        !(host_sleep_wake.oe || pull_h);
    assign periph_sleep_wake_in =
        !(periph_sleep_wake.oe || pull_p);
    // pmos conducts while its gate is pulled low
    assign vbus_on = port1_power_switch_n.oe;
    // dma controller grants a pending request after lat+1 cycles
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wh <= 4'h0;
            wp <= 4'h0;
        end
        else
        begin
            wh <= (dma_req_host != pol) ? 4'h0 : wh + 4'(wh <= lat);
            wp <= (dma_req_periph != pol) ? 4'h0 : wp + 4'(wp <= lat);
        end
    end
    assign dma_ack_host = (wh > lat) ? pol : !pol;
    assign dma_ack_periph = (wp > lat) ? pol : !pol;
endmodule : sbs_far_side

// File: tb/sbs_sideband_checker.sv
`include "sbs_consts.svh"

module sbs_sideband_checker (
    input wire logic pclk,
    input wire logic presetn,
    input sbs_pkg::sbs_apb_req_s apb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic host_ctrl_suspend,
    input wire logic periph_ctrl_suspend,
    input wire logic host_ctrl_wake,
    input wire logic periph_ctrl_wake,
    input sbs_pkg::sbs_od_s host_sleep_wake,
    input sbs_pkg::sbs_od_s periph_sleep_wake,
    input sbs_pkg::sbs_od_s port1_power_switch_n
);
    import sbs_pkg::*;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // bus answers after exactly one wait state
    AST_ONE_WAIT: assert property ((apb.psel && !apb.penable) ##1
        (apb.psel && apb.penable) |=> pready) else $error("pready late");
    AST_ERR_READY: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    AST_DATA_IDLE: assert property (!pready |-> prdata == 32'h0)
        else $error("prdata not zero");
    // sleep/wake pins: released in suspend, driven low when awake
    AST_HOST_REL: assert property ($rose(host_ctrl_suspend) |=>
        !host_sleep_wake.oe) else $error("host pin not released");
    AST_HOST_DRV: assert property (!host_ctrl_suspend |=>
        host_sleep_wake.oe) else $error("host pin not driven");
    AST_PER_REL: assert property ($rose(periph_ctrl_suspend) |=>
        !periph_sleep_wake.oe) else $error("periph pin not released");
    AST_PER_DRV: assert property (!periph_ctrl_suspend |=>
        periph_sleep_wake.oe) else $error("periph pin not driven");
    // a wake is a single pulse and the pin is driven again soon
    AST_HOST_WAKE: assert property (host_ctrl_wake |=>
        !host_ctrl_wake ##[0:1] host_sleep_wake.oe)
        else $error("host wake pulse wrong");
    AST_PER_WAKE: assert property (periph_ctrl_wake |=>
        !periph_ctrl_wake ##[0:1] periph_sleep_wake.oe)
        else $error("periph wake pulse wrong");
    // power switch follows a control write two edges later
    AST_POWER: assert property (apb.psel && apb.penable &&
        pready && apb.pwrite
        && apb.paddr == {2'b00, `SBS_IDX_CONTROL, 2'b00}
        |-> ##2 port1_power_switch_n.oe == $past(apb.pwdata[0], 2))
        else $error("power switch not updated");
    AST_OD_LOW: assert property (!port1_power_switch_n.out &&
        !host_sleep_wake.out && !periph_sleep_wake.out)
        else $error("open-drain pin driven high");
endmodule : sbs_sideband_checker

bind sbs_sideband sbs_sideband_checker i_chk (.pclk, .presetn, .apb,
    .prdata, .pready, .pslverr, .host_ctrl_suspend, .periph_ctrl_suspend,
    .host_ctrl_wake, .periph_ctrl_wake, .host_sleep_wake,
    .periph_sleep_wake, .port1_power_switch_n);

// File: tb/tb_sbs_sideband.sv
`include "sbs_consts.svh"

module tb_sbs_sideband;
    timeunit 1ns;
    timeprecision 1ps;
    import sbs_pkg::*;
    localparam logic [7:0] a_hw = `SBS_IDX_HOST_CFG_WR;
    localparam logic [7:0] a_pw = `SBS_IDX_PER_CFG_WR;
    localparam logic [7:0] a_st = `SBS_IDX_IRQ_STATUS;
    localparam logic [7:0] a_cl = `SBS_IDX_IRQ_CLEAR;
    localparam logic [7:0] a_en = `SBS_IDX_IRQ_ENABLE;
    localparam logic [7:0] a_ct = `SBS_IDX_CONTROL;
    logic pclk, presetn, pready, pslverr, sb_irq, er, ex, pol, vbus_on;
    sbs_apb_req_s apb;
    logic [31:0] prdata, rd, cv;
    logic host_ctrl_irq, periph_ctrl_irq, host_ctrl_dma_req;
    logic periph_ctrl_dma_req, host_ctrl_suspend, periph_ctrl_suspend;
    logic host_ctrl_dma_grant, periph_ctrl_dma_grant, host_ctrl_wake;
    logic periph_ctrl_wake, dma_ack_host, dma_ack_periph, dma_req_host;
    logic dma_req_periph, irq_host_out, irq_periph_out, pull_h, pull_p;
    logic host_sleep_wake_in, periph_sleep_wake_in;
    sbs_od_s host_sleep_wake, periph_sleep_wake, port1_power_switch_n;
    logic [3:0] lat;
    int err_total, total_checks, wakes_h, wakes_p;

    sbs_sideband i_dut (.pclk, .presetn, .apb, .prdata, .pready, .pslverr,
        .host_ctrl_irq, .periph_ctrl_irq, .host_ctrl_dma_req,
        .periph_ctrl_dma_req, .host_ctrl_suspend, .periph_ctrl_suspend,
        .host_ctrl_dma_grant, .periph_ctrl_dma_grant, .host_ctrl_wake,
        .periph_ctrl_wake, .dma_ack_host, .dma_ack_periph, .dma_req_host,
        .dma_req_periph, .irq_host_out, .irq_periph_out,
        .host_sleep_wake_in, .host_sleep_wake, .periph_sleep_wake_in,
        .periph_sleep_wake, .port1_power_switch_n, .sb_irq);
    sbs_far_side i_far (.pclk, .presetn, .pol, .lat, .pull_h, .pull_p,
        .dma_req_host, .dma_req_periph, .host_sleep_wake,
        .periph_sleep_wake, .port1_power_switch_n, .dma_ack_host,
        .dma_ack_periph, .host_sleep_wake_in, .periph_sleep_wake_in,
        .vbus_on);

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : print_verdict

    task automatic wt(input int k);
        repeat (k) @(posedge pclk);
    endtask : wt

    // one apb transfer; read data and error land in rd and er
    task automatic xfer(input logic w, input logic [7:0] idx,
        input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        apb <= '{1'b1, 1'b0, w, {2'b00, idx, 2'b00}, d};
        @(posedge pclk);
        apb.penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 16)
        begin
            @(posedge pclk);
            n++;
        end
        if (n == 16)
            chk(0, 1);
        rd = prdata;
        er = pslverr;
        apb <= '0;
    endtask : xfer

    task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp);
        xfer(1'b0, idx, 32'h0);
        chk(rd, exp);
    endtask : rdchk

    initial
    begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    // count wake pulses; a woken controller leaves suspend
    always @(posedge pclk)
    begin
        if (host_ctrl_wake === 1'b1)
        begin
            wakes_h++;
            host_ctrl_suspend <= 1'b0;
        end
        if (periph_ctrl_wake === 1'b1)
        begin
            wakes_p++;
            periph_ctrl_suspend <= 1'b0;
        end
    end

    initial
    begin
        #100000;
        err_total++;
        print_verdict();
    end

    // main sequence
    initial
    begin
        presetn = 1'b0;
        apb = '0;
        {host_ctrl_irq, periph_ctrl_irq, host_ctrl_dma_req} = 3'h0;
        {periph_ctrl_dma_req, host_ctrl_suspend, periph_ctrl_suspend} = 3'h0;
        {pol, pull_h, pull_p, lat} = 7'h0;
        wt(20);
        presetn <= 1'b1;
        chk(irq_host_out, 1);
        chk(dma_req_host, 1);
        chk(vbus_on, 0);
        rdchk(`SBS_IDX_HOST_CFG_RD, 0);
        rdchk(`SBS_IDX_PER_CFG_RD, 0);
        rdchk(`SBS_IDX_LINE_STATUS, 32'h60);
        rdchk(a_en, 0);
        xfer(1'b0, 8'h00, 32'h0);
        chk(er, 1);
        chk(rd, 0);
        xfer(1'b1, a_st, 32'hf);
        rdchk(a_st, 0);
        xfer(1'b1, a_hw, '1);
        rdchk(`SBS_IDX_HOST_CFG_RD, 32'h3f);
        xfer(1'b1, `SBS_IDX_PER_CFG_RD, '1);
        rdchk(a_pw, 32'h27);
        for (int i = 0; i < 8; i++)
        begin
            cv = {26'h0, i[2], 4'h0, i[1]};
            xfer(1'b1, a_hw, cv);
            xfer(1'b1, a_pw, cv);
            host_ctrl_irq <= i[0];
            periph_ctrl_irq <= i[0];
            wt(4);
            ex = (i[2] && i[0]) ? i[1] : !i[1];
            chk(irq_host_out, ex);
            chk(irq_periph_out, ex);
        end
        xfer(1'b1, a_hw, 32'h28);
        xfer(1'b1, a_pw, 32'h20);
        host_ctrl_irq <= 1'b0;
        wt(4);
        chk(irq_host_out, 0);
        chk(irq_periph_out, 1);
        xfer(1'b1, a_cl, 32'hf);
        for (int p = 0; p < 4; p++)
        begin
            pol <= p[0];
            lat <= 4'(p * 3);
            cv = {27'h0, p[1], 1'b0, p[0], p[0], 1'b0};
            xfer(1'b1, a_hw, cv);
            xfer(1'b1, a_pw, cv);
            periph_ctrl_dma_req <= 1'b1;
            wt(20);
            chk(dma_req_periph, p[1] ? !p[0] : p[0]);
            chk(dma_req_host, p[1] ? p[0] : !p[0]);
            chk(periph_ctrl_dma_grant, 1);
            chk(host_ctrl_dma_grant, 0);
            periph_ctrl_dma_req <= 1'b0;
            host_ctrl_dma_req <= 1'b1;
            wt(20);
            chk(host_ctrl_dma_grant, 1);
            chk(periph_ctrl_dma_grant, 0);
            host_ctrl_dma_req <= 1'b0;
            wt(20);
        end
        rdchk(a_st, 32'hc);
        chk(sb_irq, 0);
        xfer(1'b1, a_en, 32'h8);
        wt(3);
        chk(sb_irq, 1);
        xfer(1'b1, a_cl, 32'h8);
        wt(3);
        chk(sb_irq, 0);
        rdchk(a_st, 32'h4);
        rdchk(a_cl, 0);
        host_ctrl_suspend <= 1'b1;
        periph_ctrl_suspend <= 1'b1;
        wt(8);
        chk(host_sleep_wake_in, 1);
        chk(periph_sleep_wake_in, 1);
        {pull_h, pull_p} <= 2'b11;
        wt(2);
        {pull_h, pull_p} <= 2'b00;
        wt(12);
        chk(wakes_h + wakes_p, 0);
        pull_h <= 1'b1;
        wt(10);
        pull_h <= 1'b0;
        wt(12);
        chk(wakes_h, 1);
        chk(wakes_p, 0);
        pull_p <= 1'b1;
        wt(10);
        pull_p <= 1'b0;
        wt(12);
        chk(wakes_p, 1);
        rdchk(a_st, 32'h7);
        xfer(1'b1, a_ct, 32'h1);
        wt(3);
        chk(vbus_on, 1);
        rdchk(a_ct, 32'h1);
        xfer(1'b1, a_ct, 32'h0);
        wt(3);
        chk(vbus_on, 0);
        print_verdict();
    end
endmodule : tb_sbs_sideband
